// *** hdl/nibble_cpu_load_move_decode.sv ***
// Purpose: Decode and execute immediate, move and RAM-address instructions
// Assumes: One instruction word offered per cycle with instr_valid; ce freezes all
// Notes:   Words are registered, then executed one cycle later
// What this block does
// RULE_01: Upper bits 100011 load the 4-bit immediate into the accumulator, one cycle.
// RULE_02: Upper bits 100000 load the 4-bit immediate into the auxiliary register.
// RULE_03: Immediate-to-RAM direct store takes two words; second word is the address.
// RULE_04: Upper bits 101001 store immediate at pointer, increment digit, status not-zero.
// RULE_05: Page-to-accumulator takes two words; the second word is fetched and dropped.
// RULE_06: Accumulator-to-page takes two words; the second word is fetched and dropped.
// RULE_07: Upper bits 00111100 load the 2-bit immediate into the page register.
// RULE_08: Upper bits 100010 load the 4-bit immediate into the column register.
// RULE_09: Upper bits 100001 load the 4-bit immediate into the digit pointer.
// RULE_10: Upper bits 100111 copy the selected slot into the accumulator.
// RULE_11: Upper bits 101111 swap the accumulator with the selected slot.
// RULE_12: Add accumulator to digit pointer; status takes the carry out.
// RULE_13: Subtract accumulator from digit pointer; status takes no-borrow.
// RULE_14: Swap column with spare, digit with spare, or both pairs.
// RULE_15: Page, column and digit form the 10-bit indirect RAM address.
// RULE_16: The sixteen slots are RAM nibbles 040 to 04F hex.
// RULE_17: Plain one-word moves among accumulator, auxiliary, pointers and spares.
// RULE_18: Increment digit with not-zero status; decrement with no-borrow status.
// RULE_19: Instructions without a status effect leave status unchanged.
`timescale 1ns/1ps
`include "nibble_decode_defs.svh"
module nibble_cpu_load_move_decode
  import nibble_decode_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // Instruction stream
  input  wire logic [9:0] instr_word,
  input  wire logic       instr_valid,
  // Architectural state
  output logic [3:0]      acc,
  output logic [3:0]      aux,
  output logic [1:0]      page,
  output logic [3:0]      col,
  output logic [3:0]      digit,
  output logic [3:0]      col_spare,
  output logic [3:0]      digit_spare,
  output logic            status,
  output logic            second_word
);
  nib_t   acc_q, acc_d, aux_q, aux_d, col_q, col_d, digit_q, digit_d;
  nib_t   cspare_q, cspare_d, dspare_q, dspare_d, held_q, held_d;
  logic [1:0] page_q, page_d;
  logic   status_q, status_d, irv_q, irv_d, direct_q, direct_d;
  word_t  ir_q, ir_d;
  phase_t phase_q, phase_d;
  logic [4:0] inc_w, dec_w, add_w, sub_w;
  logic   exec;
  logic   sw_q, sw_d;

  nib_mem_if #(.AW(10), .DW(4)) mem_bus ();

  nib_ram #(.AW(10), .DW(4)) u_ram (
    .ref_clk (ref_clk),
    .ce      (ce),
    .port    (mem_bus.mem)
  );

  assign exec  = irv_q && (phase_q == PH_OPCODE);
  assign inc_w = {1'b0, digit_q} + `NIB_ONE;
  assign dec_w = {1'b0, digit_q} - `NIB_ONE;
  assign add_w = {1'b0, digit_q} + {1'b0, acc_q};
  assign sub_w = {1'b0, digit_q} - {1'b0, acc_q};
  // Slot read is launched from the incoming word so data is ready at execute
  assign mem_bus.raddr = {`SLOT_BASE_HI, instr_word[`IMM4_F]}; // [RULE_16]

  always_comb
  begin
    acc_d    = acc_q;
    aux_d    = aux_q;
    page_d   = page_q;
    col_d    = col_q;
    digit_d  = digit_q;
    cspare_d = cspare_q;
    dspare_d = dspare_q;
    status_d = status_q; // [RULE_19]
    held_d   = held_q;
    direct_d = direct_q;
    phase_d  = phase_q;
    ir_d     = instr_word;
    irv_d    = instr_valid;
    mem_bus.we    = 1'b0;
    mem_bus.waddr = {page_q, col_q, digit_q}; // [RULE_15]
    mem_bus.wdata = ir_q[`IMM4_F];
    if (irv_q)
    begin
      unique case (phase_q)
        PH_OPERAND:
        begin
          // Second word: an address for the direct store, else a filler
          phase_d = PH_OPCODE; // [RULE_05] [RULE_06]
          if (direct_q)
          begin
            mem_bus.we    = 1'b1; // [RULE_03]
            mem_bus.waddr = ir_q;
            mem_bus.wdata = held_q;
          end
        end
        PH_OPCODE:
        begin
          casez (ir_q)
            `PAT_IMM_ACC:   acc_d   = ir_q[`IMM4_F]; // [RULE_01]
            `PAT_IMM_AUX:   aux_d   = ir_q[`IMM4_F]; // [RULE_02]
            `PAT_IMM_PAGE:  page_d  = ir_q[`IMM2_F]; // [RULE_07]
            `PAT_IMM_COL:   col_d   = ir_q[`IMM4_F]; // [RULE_08]
            `PAT_IMM_DIGIT: digit_d = ir_q[`IMM4_F]; // [RULE_09]
            `PAT_SLOT_ACC:  acc_d   = mem_bus.rdata; // [RULE_10]
            `PAT_SLOT_SWAP:
            begin
              acc_d         = mem_bus.rdata; // [RULE_11]
              mem_bus.we    = 1'b1;
              mem_bus.waddr = {`SLOT_BASE_HI, ir_q[`IMM4_F]};
              mem_bus.wdata = acc_q;
            end
            `PAT_IMM_RAM_INC:
            begin
              mem_bus.we = 1'b1; // [RULE_04]
              digit_d    = inc_w[3:0];
              status_d   = (inc_w[3:0] != `NIB_RST);
            end
            `PAT_IMM_RAM_DIR:
            begin
              held_d   = ir_q[`IMM4_F]; // [RULE_03]
              direct_d = 1'b1;
              phase_d  = PH_OPERAND;
            end
            `OP_PAGE_TO_ACC:
            begin
              acc_d    = {2'b00, page_q}; // [RULE_05]
              direct_d = 1'b0;
              phase_d  = PH_OPERAND;
            end
            `OP_ACC_TO_PAGE:
            begin
              page_d   = acc_q[`IMM2_F]; // [RULE_06]
              direct_d = 1'b0;
              phase_d  = PH_OPERAND;
            end
            `OP_AUX_TO_ACC:    acc_d   = aux_q;    // [RULE_17]
            `OP_ACC_TO_AUX:    aux_d   = acc_q;    // [RULE_17]
            `OP_DIGIT_TO_ACC:  acc_d   = digit_q;  // [RULE_17]
            `OP_CSPARE_TO_ACC: acc_d   = cspare_q; // [RULE_17]
            `OP_DSPARE_TO_ACC: acc_d   = dspare_q; // [RULE_17]
            `OP_ACC_TO_COL:    col_d   = acc_q;    // [RULE_17]
            `OP_ACC_TO_DIGIT:  digit_d = acc_q;    // [RULE_17]
            `OP_PTR_INC:
            begin
              digit_d  = inc_w[3:0]; // [RULE_18]
              status_d = (inc_w[3:0] != `NIB_RST);
            end
            `OP_PTR_DEC:
            begin
              digit_d  = dec_w[3:0]; // [RULE_18]
              status_d = ~dec_w[4];
            end
            `OP_PTR_ADD:
            begin
              digit_d  = add_w[3:0]; // [RULE_12]
              status_d = add_w[4];
            end
            `OP_PTR_SUB:
            begin
              digit_d  = sub_w[3:0]; // [RULE_13]
              status_d = ~sub_w[4];
            end
            `OP_COL_SWAP:
            begin
              col_d    = cspare_q; // [RULE_14]
              cspare_d = col_q;
            end
            `OP_DIGIT_SWAP:
            begin
              digit_d  = dspare_q; // [RULE_14]
              dspare_d = digit_q;
            end
            `OP_BOTH_SWAP:
            begin
              col_d    = cspare_q; // [RULE_14]
              cspare_d = col_q;
              digit_d  = dspare_q;
              dspare_d = digit_q;
            end
            // Words outside these groups belong to other decoders
            default: acc_d = acc_q;
          endcase
        end
      endcase
    end
    // Own flop so the pin never carries decode glitches
    sw_d = (phase_d == PH_OPERAND);
  end

  // Clock enable gates every flop so the whole core freezes together
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_q    <= `NIB_RST;
      aux_q    <= `NIB_RST;
      page_q   <= `PAGE_RST;
      col_q    <= `NIB_RST;
      digit_q  <= `NIB_RST;
      cspare_q <= `NIB_RST;
      dspare_q <= `NIB_RST;
      held_q   <= `NIB_RST;
      status_q <= `STATUS_RST;
      direct_q <= 1'b0;
      irv_q    <= 1'b0;
      ir_q     <= `WORD_RST;
      phase_q  <= PH_OPCODE;
      sw_q     <= 1'b0;
    end
    else if (ce)
    begin
      acc_q    <= acc_d;
      aux_q    <= aux_d;
      page_q   <= page_d;
      col_q    <= col_d;
      digit_q  <= digit_d;
      cspare_q <= cspare_d;
      dspare_q <= dspare_d;
      held_q   <= held_d;
      status_q <= status_d;
      direct_q <= direct_d;
      irv_q    <= irv_d;
      ir_q     <= ir_d;
      phase_q  <= phase_d;
      sw_q     <= sw_d;
    end
  end

  assign acc         = acc_q;
  assign aux         = aux_q;
  assign page        = page_q;
  assign col         = col_q;
  assign digit       = digit_q;
  assign col_spare   = cspare_q;
  assign digit_spare = dspare_q;
  assign status      = status_q;
  assign second_word = sw_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  imm_acc_load_a: assert property (ce && exec && (ir_q ==? `PAT_IMM_ACC) |=> // [RULE_01]
    acc_q == $past(ir_q[`IMM4_F])) else $error("immediate not loaded into accumulator");
  imm_aux_load_a: assert property (ce && exec && (ir_q ==? `PAT_IMM_AUX) |=> // [RULE_02]
    aux_q == $past(ir_q[`IMM4_F])) else $error("immediate not loaded into auxiliary");
  direct_store_a: assert property (ce && exec && (ir_q ==? `PAT_IMM_RAM_DIR) // [RULE_03]
    ##1 (ce && irv_q) |-> mem_bus.we && (mem_bus.waddr == ir_q)
    && (mem_bus.wdata == held_q)) else $error("direct store not written at operand word");
  ptr_store_inc_a: assert property (ce && exec && (ir_q ==? `PAT_IMM_RAM_INC) |-> // [RULE_04]
    mem_bus.we && (mem_bus.waddr == {page_q, col_q, digit_q})
    ##1 (digit_q == $past(digit_q) + 4'h1) && (status_q == (digit_q != `NIB_RST)))
    else $error("pointer store or increment wrong");
  page_two_word_a: assert property (ce && exec // [RULE_05]
    && ((ir_q == `OP_PAGE_TO_ACC) || (ir_q == `OP_ACC_TO_PAGE)) |=> second_word)
    else $error("two-word move did not wait for second word");
  page_to_acc_a: assert property (ce && exec && (ir_q == `OP_PAGE_TO_ACC) |=> // [RULE_05]
    acc_q == {2'b00, $past(page_q)}) else $error("page not copied to accumulator");
  imm_page_load_a: assert property (ce && exec && (ir_q ==? `PAT_IMM_PAGE) |=> // [RULE_07]
    page_q == $past(ir_q[`IMM2_F])) else $error("page immediate not loaded");
  slot_swap_a: assert property (ce && exec && (ir_q ==? `PAT_SLOT_SWAP) |-> mem_bus.we // [RULE_11]
    && (mem_bus.waddr[`SLOT_HI_F] == `SLOT_BASE_HI) && (mem_bus.wdata == acc_q))
    else $error("slot swap did not write back accumulator");
  ptr_add_a: assert property (ce && exec && (ir_q == `OP_PTR_ADD) |=> // [RULE_12]
    {status_q, digit_q} == $past(add_w)) else $error("pointer add result wrong");
  ptr_sub_a: assert property (ce && exec && (ir_q == `OP_PTR_SUB) |=> // [RULE_13]
    (digit_q == $past(sub_w[3:0])) && (status_q == !$past(sub_w[4])))
    else $error("pointer subtract result wrong");
  both_swap_a: assert property (ce && exec && (ir_q == `OP_BOTH_SWAP) |=> // [RULE_14]
    (col_q == $past(cspare_q)) && (digit_spare == $past(digit_q)))
    else $error("spare swap wrong");
  status_hold_a: assert property (ce && exec && (ir_q == `OP_AUX_TO_ACC) |=> // [RULE_19]
    $stable(status_q)) else $error("status changed by move");

  cov_direct: cover property (ce && exec && (ir_q ==? `PAT_IMM_RAM_DIR) ##1 ce && irv_q);
  cov_slot_rd: cover property (ce && exec && (ir_q ==? `PAT_SLOT_ACC));
  cov_dec_wrap: cover property (ce && exec && (ir_q == `OP_PTR_DEC) && (digit_q == `NIB_RST));
endmodule

// *** hdl/nibble_decode_defs.svh ***
// Purpose: Opcode patterns, field ranges and reset values of the load/move decoder
// Assumes: 10-bit instruction words, 4-bit data nibbles
// Notes:   Patterns are casez / wildcard-equality forms
`ifndef NIBBLE_DECODE_DEFS_SVH
`define NIBBLE_DECODE_DEFS_SVH

// Field ranges
`define IMM4_F      3:0
`define IMM2_F      1:0
`define SLOT_HI_F   9:4

// One-word immediate loads, pointer store and slot moves
`define PAT_IMM_ACC      10'b100011????
`define PAT_IMM_AUX      10'b100000????
`define PAT_IMM_RAM_INC  10'b101001????
`define PAT_IMM_PAGE     10'b00111100??
`define PAT_IMM_COL      10'b100010????
`define PAT_IMM_DIGIT    10'b100001????
`define PAT_SLOT_ACC     10'b100111????
`define PAT_SLOT_SWAP    10'b101111????
// Two-word opcodes; second word is an address or a filler
`define PAT_IMM_RAM_DIR  10'b011001????
`define OP_PAGE_TO_ACC   10'h100
`define OP_ACC_TO_PAGE   10'h110
// One-word moves
`define OP_AUX_TO_ACC    10'h048
`define OP_ACC_TO_AUX    10'h0C8
`define OP_DIGIT_TO_ACC  10'h0AF
`define OP_CSPARE_TO_ACC 10'h068
`define OP_DSPARE_TO_ACC 10'h058
`define OP_ACC_TO_COL    10'h0E8
`define OP_ACC_TO_DIGIT  10'h0D8
// Pointer arithmetic and spare swaps
`define OP_PTR_INC       10'h05C
`define OP_PTR_DEC       10'h0DF
`define OP_PTR_ADD       10'h054
`define OP_PTR_SUB       10'h0D4
`define OP_COL_SWAP      10'h001
`define OP_DIGIT_SWAP    10'h002
`define OP_BOTH_SWAP     10'h003

// Slot window base and unit step
`define SLOT_BASE_HI     6'h04
`define NIB_ONE          5'h01

// Reset values
`define NIB_RST          4'h0
`define PAGE_RST         2'h0
`define STATUS_RST       1'b0
`define WORD_RST         10'h000

`endif

// *** hdl/nibble_decode_pkg.sv ***
// Purpose: Shared types of the load/move decoder
// Assumes: Nothing beyond the defs header
// Notes:   Types only; constants live in the defs header
package nibble_decode_pkg;
  typedef logic [3:0] nib_t;
  typedef logic [9:0] word_t;
  typedef enum logic {PH_OPCODE, PH_OPERAND} phase_t;
endpackage

// *** hdl/nib_mem_if.sv ***
// Purpose: Carrier between the decoder core and its nibble RAM
// Assumes: One clock shared by both ends
// Notes:   Read address is sampled every enabled edge
`timescale 1ns/1ps
interface nib_mem_if #(parameter int AW = 10, parameter int DW = 4);
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  modport core (output raddr, we, waddr, wdata, input rdata);
  modport mem  (input raddr, we, waddr, wdata, output rdata);
endinterface

// *** hdl/nib_ram.sv ***
// Purpose: Nibble RAM with registered read data
// Assumes: Write and read addresses arrive on the same edge
// Notes:   Write-first bypass so a read follows a write to the same nibble
`timescale 1ns/1ps
module nib_ram #(
  parameter int AW = 10,
  parameter int DW = 4
) (
  // Clock
  input wire logic ref_clk,
  input wire logic ce,
  // Memory side of the carrier
  nib_mem_if.mem   port
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;
  logic [DW-1:0] rd_d;

  always_comb
  begin
    rd_d = mem_q[port.raddr];
    // Bypass keeps back-to-back store then slot read coherent
    if (port.we && (port.waddr == port.raddr))
    begin
      rd_d = port.wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (ce)
    begin
      rd_q <= rd_d;
      if (port.we)
      begin
        mem_q[port.waddr] <= port.wdata;
      end
    end
  end

  assign port.rdata = rd_q;
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the load/move/RAM-address decoder
// Assumes: ce stays high except in the freeze case; slots are written before read
// Notes:   A reference model runs beside the driver and queues the expected state
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((e) !== (g)) \
    begin \
      failures++; \
      $display("[FAIL] %s exp=%h got=%h", nm, e, g); \
    end \
  end
module tb_top
  import nibble_decode_pkg::*;
;
  typedef struct {int due; logic [27:0] st;} note_t;
  localparam word_t OPS[26] = '{10'h230, 10'h200, 10'h190, 10'h290, 10'h270, 10'h2F0,
    10'h220, 10'h210, 10'h0F0, 10'h100, 10'h110, 10'h054, 10'h0D4, 10'h001, 10'h002,
    10'h003, 10'h048, 10'h0C8, 10'h0AF, 10'h068, 10'h058, 10'h0E8, 10'h0D8, 10'h05C,
    10'h0DF, 10'h000};
  localparam word_t DIR[21] = '{10'h21F, 10'h05C, 10'h0DF, 10'h0DF, 10'h231, 10'h21F,
    10'h054, 10'h232, 10'h211, 10'h0D4, 10'h21F, 10'h29C, 10'h27F, 10'h100, 10'h235,
    10'h232, 10'h110, 10'h190, 10'h000, 10'h0AF, 10'h003};
  logic        ref_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        ce          = 1'b1;
  word_t       instr_word  = 10'h000;
  logic        instr_valid = 1'b0;
  nib_t        acc, aux, col, digit, col_spare, digit_spare;
  logic [1:0]  page;
  logic        status, second_word;
  wire  [27:0] obs = {acc, aux, page, col, digit, col_spare, digit_spare, status, second_word};
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  note_t       q[$];
  nib_t        mem[1024];
  nib_t        m_acc, m_aux, m_col, m_dig, m_cs, m_ds, m_imm;
  logic [1:0]  m_page;
  logic        m_st, m_sw, m_store;

  nibble_cpu_load_move_decode i_nibble_cpu_load_move_decode (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
    .instr_word(instr_word), .instr_valid(instr_valid),
    .acc(acc), .aux(aux), .page(page), .col(col), .digit(digit),
    .col_spare(col_spare), .digit_spare(digit_spare),
    .status(status), .second_word(second_word)
  );

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts only enabled edges, so due times survive a freeze
  always @(posedge ref_clk)
    if (ce) cyc <= cyc + 1;

  function automatic logic [27:0] mvec();
    return {m_acc, m_aux, m_page, m_col, m_dig, m_cs, m_ds, m_st, m_sw};
  endfunction

  task automatic mreset();
    {m_acc, m_aux, m_page, m_col, m_dig, m_cs, m_ds, m_st, m_sw, m_store} = '0;
  endtask

  // Reference model: one word per call, bubbles leave everything alone
  task automatic step(word_t w, logic v);
    nib_t t;
    t = w[3:0];
    if (!v) return;
    if (m_sw)
    begin
      if (m_store) mem[w] = m_imm;
      m_sw = 1'b0;
      return;
    end
    casez (w)
      10'b100011????: m_acc = t;
      10'b100000????: m_aux = t;
      10'b011001????: {m_sw, m_store, m_imm} = {2'b11, t};
      10'b101001????:
      begin
        mem[{m_page, m_col, m_dig}] = t;
        {m_st, m_dig} = {m_dig != 4'hF, m_dig + 4'h1};
      end
      10'h100:        {m_sw, m_store, m_acc} = {4'b1000, m_page};
      10'h110:        {m_sw, m_store, m_page} = {2'b10, m_acc[1:0]};
      10'b00111100??: m_page = w[1:0];
      10'b100010????: m_col = t;
      10'b100001????: m_dig = t;
      10'b100111????: m_acc = mem[{6'h04, t}];
      10'b101111????: {m_acc, mem[{6'h04, t}]} = {mem[{6'h04, t}], m_acc};
      10'h054:        {m_st, m_dig} = m_dig + m_acc;
      10'h0D4:        {m_st, m_dig} = {m_dig >= m_acc, m_dig - m_acc};
      10'h001:        {m_col, m_cs} = {m_cs, m_col};
      10'h002:        {m_dig, m_ds} = {m_ds, m_dig};
      10'h003:        {m_col, m_cs, m_dig, m_ds} = {m_cs, m_col, m_ds, m_dig};
      10'h048:        m_acc = m_aux;
      10'h0C8:        m_aux = m_acc;
      10'h0AF:        m_acc = m_dig;
      10'h068:        m_acc = m_cs;
      10'h058:        m_acc = m_ds;
      10'h0E8:        m_col = m_acc;
      10'h0D8:        m_dig = m_acc;
      10'h05C:        {m_st, m_dig} = {m_dig != 4'hF, m_dig + 4'h1};
      10'h0DF:        {m_st, m_dig} = {m_dig != 4'h0, m_dig - 4'h1};
      default:        ;
    endcase
  endtask

  // Word offered now is registered next edge and shows after the one after
  task automatic issue(word_t w, logic v);
    @(posedge ref_clk);
    instr_word <= w;
    instr_valid <= v;
    step(w, v);
    q.push_back('{cyc + 3, mvec()});
  endtask

  function automatic word_t pick(int k);
    nib_t r;
    r = 4'($urandom_range(15));
    return OPS[k] | (k < 8 ? {6'h00, r} : k == 8 ? {8'h00, r[1:0]} : 10'h000);
  endfunction

  // A stray word offered while frozen must never be taken
  task automatic freeze();
    @(posedge ref_clk);
    ce <= 1'b0;
    instr_word <= 10'h23A;
    instr_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    instr_valid <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    instr_valid <= 1'b0;
    q.delete();
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("reset state", 28'h0000000, obs)
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    mreset();
  endtask

  task automatic results();
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(negedge ref_clk)
  begin
    if (q.size() > 0 && q[0].due == cyc)
    begin
      `CHK("acc", q[0].st[27:24], obs[27:24])
      `CHK("regs", q[0].st[23:2], obs[23:2])
      `CHK("status", q[0].st[1], obs[1])
      `CHK("second word", q[0].st[0], obs[0])
      void'(q.pop_front());
    end
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    results();
  end

  initial
  begin
    word_t w;
    void'($urandom(32'hF4D4172A));
    mreset();
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Page 1, column 0 points the indirect address at nibbles 100 to 10F hex
    issue(10'h0F1, 1'b1);
    issue(10'h220, 1'b1);
    for (int m = 0; m < 16; m++)
    begin
      issue({6'h19, 4'($urandom_range(15))}, 1'b1);
      issue({6'h04, 4'(m)}, 1'b1);
      issue({6'h27, 4'(m)}, 1'b1);
    end
    foreach (DIR[i]) issue(DIR[i], 1'b1);
    // Bubble between a two-word opcode and its filler
    issue(10'h100, 1'b1);
    issue(10'h23C, 1'b0);
    issue(10'h237, 1'b1);
    issue(10'h233, 1'b1);
    issue(10'h205, 1'b1);
    freeze();
    issue(10'h048, 1'b1);
    for (int k = 0; k < 26; k++) issue(pick(k), 1'b1);
    for (int k = 0; k < 600; k++)
    begin
      w = ($urandom_range(3) == 0) ? 10'($urandom) : pick($urandom_range(25));
      issue(w, $urandom_range(7) != 0);
    end
    repeat (4) issue(10'h000, 1'b0);
    // Reset between a direct store and its address word
    issue(10'h19A, 1'b1);
    do_reset();
    issue(10'h235, 1'b1);
    issue(10'h0C8, 1'b1);
    repeat (4) issue(10'h000, 1'b0);
    results();
  end
endmodule
